// ==== include/pmu_regs_pkg.sv ====
// Register map, field layout and reset values of the monitor register bank
package pmu_regs_pkg;

  // Bus geometry
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned NUM_EVT = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_OVF_CLEAR  = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_OVF_SET    = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CLK_GATE   = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CAPS       = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_GLOBAL_CTL = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR  = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h1c;

  // Overflow flag layout, shared by the clear and set views
  localparam int unsigned OVF_CYC_BIT = 31;
  localparam int unsigned OVF_EVT_LSB = 0;
  localparam int unsigned OVF_W       = NUM_EVT + 1;  // Packed {cycle, events}

  // Clock gating control
  localparam int unsigned CG_DRIVE_BIT = 0;
  localparam logic        CG_RESET     = 1'b0;

  // Capability fields
  localparam int unsigned CAP_SNAPSHOT_BIT = 22;
  localparam int unsigned CAP_EXPORT_BIT   = 16;
  localparam int unsigned CAP_CYCLE_BIT    = 14;
  localparam int unsigned CAP_SIZE_LSB     = 8;
  localparam logic [5:0]  CAP_SIZE_VAL     = 6'h3f;
  localparam int unsigned CAP_NUM_LSB      = 0;
  localparam logic [7:0]  CAP_NUM_VAL      = 8'h08;

  // Global control fields
  localparam int unsigned GC_CYC_RST_BIT = 2;
  localparam int unsigned GC_EVT_RST_BIT = 1;
  localparam int unsigned GC_ENABLE_BIT  = 0;
  localparam logic        GC_ENABLE_RESET = 1'b0;

  // Secure access permission bits
  localparam int unsigned SEC_PERM_W = 2;

  // Interrupt status layout
  localparam int unsigned IRQ_W          = 3;
  localparam int unsigned IRQ_CYC_OVF    = 0;
  localparam int unsigned IRQ_EVT_OVF    = 1;
  localparam int unsigned IRQ_REFUSED    = 2;
  localparam logic [IRQ_W-1:0] IRQ_EN_RESET = 3'h0;

endpackage

// ==== include/flag_bank_if.sv ====
// Carrier between the register bank and a sticky flag bank
interface flag_bank_if #(parameter int unsigned W = 1);
  logic [W-1:0] hw_set;
  logic [W-1:0] sw_set;
  logic [W-1:0] sw_clr;
  logic [W-1:0] flags;

  modport bank (input hw_set, input sw_set, input sw_clr, output flags);
  modport user (output hw_set, output sw_set, output sw_clr, input flags);
endinterface

// ==== hdl/sticky_flag_bank.sv ====
// Sticky flag bits with hardware set, software set and software clear
module sticky_flag_bank #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic  hclk,
  input  wire logic  hresetn,
  // Flag controls
  flag_bank_if.bank  fb
);

  logic [W-1:0] flags_r;

  // Sets win over a clear in the same cycle, so no event is lost
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      flags_r <= '0;
    else
      flags_r <= (flags_r & ~fb.sw_clr) | fb.sw_set | fb.hw_set;
  end

  assign fb.flags = flags_r;

endmodule // sticky_flag_bank

// ==== hdl/qactive_ctl.sv ====
// Low-power activity request for the monitor's clock domain
module qactive_ctl (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Control
  input  wire logic drive_en,
  input  wire logic activity,
  // Activity output
  output logic      qactive
);

  logic qactive_r;

  // Held high when driven, otherwise follows activity and may drop
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      qactive_r <= 1'b0;
    else
      qactive_r <= drive_en | activity;
  end

  assign qactive = qactive_r;

endmodule // qactive_ctl

// ==== hdl/pmu_overflow_status_regs.sv ====
// Monitor overflow status, control and capability registers on AHB-Lite
//
// Operation
// - Non-secure access needs permission bit 0 or 1
// - Clear view bit 31: cycle overflow, W1C
// - Clear view bits 7:0: event overflows, W1C
// - Set view bit 31: cycle overflow, W1S
// - Set view bits 7:0: event overflows, W1S
// - Gating bit 0: 0 gates, 1 drives qactive
// - Capabilities read-only constants, eight counters
// - Global bit 2 resets cycle counter, reads zero
// - Global bit 1 resets event counters, reads zero
// - Global bit 0 master enable of counters
module pmu_overflow_status_regs
  import pmu_regs_pkg::*;
(
  // Clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,

  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic                  hnonsec,
  input  wire logic [DATA_W-1:0]     hwdata,
  input  wire logic                  hready,
  output logic [DATA_W-1:0]          hrdata,
  output logic                       hreadyout,
  output logic                       hresp,

  // Secure access permission bits from the node's permission register
  input  wire logic [SEC_PERM_W-1:0] secure_access_permission,

  // Counter overflow events, one-cycle pulses
  input  wire logic                  cyc_ovf_pulse,
  input  wire logic [NUM_EVT-1:0]    evt_ovf_pulse,

  // Event activity of the domain
  input  wire logic                  event_present,

  // Counter controls
  output logic                       counters_enable,
  output logic                       cyc_cnt_reset,
  output logic                       evt_cnt_reset,

  // Low-power activity and interrupt
  output logic                       qactive,
  output logic                       irq
);

  // Address phase qualification
  logic                 addr_valid;
  logic                 admitted;
  logic                 refused;
  logic [ADDR_W-1:0]    word_addr;

  // Data phase of a write
  logic                 wr_pend_r;
  logic [ADDR_W-1:0]    wr_addr_r;

  // Register state
  logic                 cg_drive_r;
  logic                 gc_enable_r;
  logic                 cyc_rst_r;
  logic                 evt_rst_r;
  logic [IRQ_W-1:0]     irq_en_r;
  logic                 irq_r;

  // Bus answer
  logic [DATA_W-1:0]    hrdata_r;
  logic [DATA_W-1:0]    rdata_nxt;
  logic                 hreadyout_r;
  logic                 hresp_r;

  // Write strobes decoded in the data phase
  logic                 wr_ovf_clr;
  logic                 wr_ovf_set;
  logic                 wr_cg;
  logic                 wr_gc;
  logic                 wr_irq_clr;
  logic                 wr_irq_en;

  // Read views of the overflow flags and capabilities, and the packed write mask
  logic [DATA_W-1:0]    ovf_view;
  logic [DATA_W-1:0]    caps_view;
  logic [OVF_W-1:0]     ovf_wmask;

  // Refused access event, one cycle
  logic                 refused_r;

  flag_bank_if #(.W(OVF_W)) ovf_fb ();
  flag_bank_if #(.W(IRQ_W)) irq_fb ();

  // A transfer starts on a NONSEQ or SEQ with the bus ready
  assign addr_valid = hsel & htrans[1] & hready;
  assign word_addr  = {haddr[ADDR_W-1:2], 2'b00};

  // Secure accesses always pass; non-secure only with a permission bit
  assign admitted = addr_valid & (~hnonsec | (|secure_access_permission));
  assign refused  = addr_valid & hnonsec & ~(|secure_access_permission);

  // Capture an admitted write for its data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end
    else
    begin
      wr_pend_r <= admitted & hwrite;
      if (admitted & hwrite)
        wr_addr_r <= word_addr;
    end
  end

  // Data phase strobes for each writable register
  assign wr_ovf_clr = wr_pend_r & (wr_addr_r == OFF_OVF_CLEAR);
  assign wr_ovf_set = wr_pend_r & (wr_addr_r == OFF_OVF_SET);
  assign wr_cg      = wr_pend_r & (wr_addr_r == OFF_CLK_GATE);
  assign wr_gc      = wr_pend_r & (wr_addr_r == OFF_GLOBAL_CTL);
  assign wr_irq_clr = wr_pend_r & (wr_addr_r == OFF_IRQ_CLEAR);
  assign wr_irq_en  = wr_pend_r & (wr_addr_r == OFF_IRQ_ENABLE);

  // Pack the cycle bit and the event bits into one flag vector
  assign ovf_wmask = {hwdata[OVF_CYC_BIT], hwdata[OVF_EVT_LSB +: NUM_EVT]};

  // Overflow flags: counters set them, the two views clear or set them
  assign ovf_fb.hw_set = {cyc_ovf_pulse, evt_ovf_pulse};
  assign ovf_fb.sw_clr = wr_ovf_clr ? ovf_wmask : '0;
  assign ovf_fb.sw_set = wr_ovf_set ? ovf_wmask : '0;

  sticky_flag_bank #(.W(OVF_W)) u_ovf_flags (
    .hclk    (hclk),
    .hresetn (hresetn),
    .fb      (ovf_fb)
  );

  // Both views read the same flags at the same positions
  always_comb
  begin
    ovf_view = '0;
    ovf_view[OVF_CYC_BIT] = ovf_fb.flags[NUM_EVT];
    ovf_view[OVF_EVT_LSB +: NUM_EVT] = ovf_fb.flags[NUM_EVT-1:0];
  end

  // Constant capability word
  always_comb
  begin
    caps_view = '0;
    caps_view[CAP_SNAPSHOT_BIT] = 1'b1;
    caps_view[CAP_EXPORT_BIT]   = 1'b1;
    caps_view[CAP_CYCLE_BIT]    = 1'b1;
    caps_view[CAP_SIZE_LSB +: 6] = CAP_SIZE_VAL;
    caps_view[CAP_NUM_LSB +: 8]  = CAP_NUM_VAL;
  end

  // Clock gating control bit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cg_drive_r <= CG_RESET;
    else if (wr_cg)
      cg_drive_r <= hwdata[CG_DRIVE_BIT];
  end

  // Master counter enable
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      gc_enable_r <= GC_ENABLE_RESET;
    else if (wr_gc)
      gc_enable_r <= hwdata[GC_ENABLE_BIT];
  end

  // Counter reset pulses, one cycle each; flags are left alone
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cyc_rst_r <= 1'b0;
      evt_rst_r <= 1'b0;
    end
    else
    begin
      cyc_rst_r <= wr_gc & hwdata[GC_CYC_RST_BIT];
      evt_rst_r <= wr_gc & hwdata[GC_EVT_RST_BIT];
    end
  end

  // Refused access becomes an interrupt event
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      refused_r <= 1'b0;
    else
      refused_r <= refused;
  end

  // Interrupt status: sticky, cleared by writing ones to the clear register
  always_comb
  begin
    irq_fb.hw_set = '0;
    irq_fb.hw_set[IRQ_CYC_OVF] = cyc_ovf_pulse;
    irq_fb.hw_set[IRQ_EVT_OVF] = |evt_ovf_pulse;
    irq_fb.hw_set[IRQ_REFUSED] = refused_r;
  end
  assign irq_fb.sw_set = '0;
  assign irq_fb.sw_clr = wr_irq_clr ? hwdata[IRQ_W-1:0] : '0;

  sticky_flag_bank #(.W(IRQ_W)) u_irq_status (
    .hclk    (hclk),
    .hresetn (hresetn),
    .fb      (irq_fb)
  );

  // Interrupt enable register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_en_r <= IRQ_EN_RESET;
    else if (wr_irq_en)
      irq_en_r <= hwdata[IRQ_W-1:0];
  end

  // Level interrupt while any enabled status bit is set
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_r <= 1'b0;
    else
      irq_r <= |(irq_fb.flags & irq_en_r);
  end

  // Activity request; bus traffic and overflows count as activity
  qactive_ctl u_qactive (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .drive_en (cg_drive_r),
    .activity (event_present | addr_valid | wr_pend_r | cyc_ovf_pulse
               | (|evt_ovf_pulse)),
    .qactive  (qactive)
  );

  // Read multiplexer; unmapped, write-only and refused reads give zero
  always_comb
  begin
    rdata_nxt = '0;
    if (admitted & ~hwrite)
    begin
      unique case (word_addr)
        OFF_OVF_CLEAR:  rdata_nxt = ovf_view;
        OFF_OVF_SET:    rdata_nxt = ovf_view;
        OFF_CLK_GATE:   rdata_nxt[CG_DRIVE_BIT] = cg_drive_r;
        OFF_CAPS:       rdata_nxt = caps_view;
        OFF_GLOBAL_CTL: rdata_nxt[GC_ENABLE_BIT] = gc_enable_r;
        OFF_IRQ_STATUS: rdata_nxt[IRQ_W-1:0] = irq_fb.flags;
        OFF_IRQ_ENABLE: rdata_nxt[IRQ_W-1:0] = irq_en_r;
        default:        rdata_nxt = '0;
      endcase
    end
  end

  // Read data registered into the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_r <= '0;
    else if (addr_valid)
      hrdata_r <= rdata_nxt;
  end

  // Zero wait states and always an OKAY response
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end
    else
    begin
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end
  end

  // Outputs straight from flip-flops
  assign hrdata          = hrdata_r;
  assign hreadyout       = hreadyout_r;
  assign hresp           = hresp_r;
  assign counters_enable = gc_enable_r;
  assign cyc_cnt_reset   = cyc_rst_r;
  assign evt_cnt_reset   = evt_rst_r;
  assign irq             = irq_r;

endmodule // pmu_overflow_status_regs

// ==== tb/pmu_regs_monitor.sv ====
// Port checker for the monitor register bank
module pmu_regs_monitor
  import pmu_regs_pkg::*;
(
  // Clock and reset
  input logic                  hclk,
  input logic                  hresetn,
  // Bus
  input logic                  hsel,
  input logic [31:0]           haddr,
  input logic [1:0]            htrans,
  input logic                  hwrite,
  input logic [2:0]            hsize,
  input logic                  hnonsec,
  input logic [DATA_W-1:0]     hwdata,
  input logic                  hready,
  input logic [DATA_W-1:0]     hrdata,
  input logic                  hreadyout,
  input logic                  hresp,
  // Side signals
  input logic [SEC_PERM_W-1:0] secure_access_permission,
  input logic                  cyc_ovf_pulse,
  input logic [NUM_EVT-1:0]    evt_ovf_pulse,
  input logic                  event_present,
  input logic                  counters_enable,
  input logic                  cyc_cnt_reset,
  input logic                  evt_cnt_reset,
  input logic                  qactive,
  input logic                  irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       wr_q;
  logic       rd_q;
  logic       ok_q;
  logic [7:0] a_q;
  wire        take = hsel && htrans[1] && hready;
  wire        gw   = wr_q && ok_q && a_q == OFF_GLOBAL_CTL;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Remember the address phase for its data phase
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      ok_q <= 1'b0;
      a_q  <= '0;
    end
    else if (hready)
    begin
      wr_q <= take && hwrite;
      rd_q <= take && !hwrite;
      ok_q <= !hnonsec || (|secure_access_permission);
      a_q  <= haddr[7:0];
    end
  AST_CYC_RST: assert property (gw && hwdata[2] |=> cyc_cnt_reset ##1 !cyc_cnt_reset)
    else $error("cycle reset pulse wrong");
  AST_EVT_RST: assert property (gw && hwdata[1] |=> evt_cnt_reset ##1 !evt_cnt_reset)
    else $error("event reset pulse wrong");
  AST_NO_RST: assert property (!(gw && hwdata[2]) |=> !cyc_cnt_reset)
    else $error("spurious cycle reset");
  AST_ENABLE: assert property (gw |=> counters_enable == $past(hwdata[0]))
    else $error("master enable not taken");
  AST_ENA_HOLD: assert property (!gw |=> $stable(counters_enable))
    else $error("master enable changed");
  AST_CAPS: assert property (rd_q && ok_q && a_q == OFF_CAPS |-> hrdata == 32'h0041_7f08)
    else $error("capability value wrong");
  AST_GLB_RAZ: assert property (rd_q && a_q == OFF_GLOBAL_CTL |-> hrdata[2:1] == 2'h0)
    else $error("reset bits read nonzero");
  AST_REFUSE: assert property (rd_q && !ok_q |-> hrdata == '0)
    else $error("refused read returned data");
  AST_QACT: assert property (event_present |=> qactive)
    else $error("activity not signalled");
  // Refused or not, every transfer ends at once with an OKAY answer
  AST_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
endmodule // pmu_regs_monitor

bind pmu_overflow_status_regs pmu_regs_monitor u_mon (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hnonsec(hnonsec), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .secure_access_permission(secure_access_permission), .cyc_ovf_pulse(cyc_ovf_pulse),
  .evt_ovf_pulse(evt_ovf_pulse), .event_present(event_present),
  .counters_enable(counters_enable), .cyc_cnt_reset(cyc_cnt_reset),
  .evt_cnt_reset(evt_cnt_reset), .qactive(qactive), .irq(irq));

// ==== tb/pmu_overflow_status_regs_bench.sv ====
// Self-checking bench for the monitor register bank
module pmu_overflow_status_regs_bench
  import pmu_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 0;
  logic        hresetn = 0;
  logic        hsel = 0;
  logic        hwrite = 0;
  logic        hnonsec = 0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [1:0]  htrans = '0;
  logic [1:0]  perm = '0;
  logic        cyc_p = 0;
  logic [7:0]  evt_p = '0;
  logic        ev_pr = 0;
  logic        rd_dp = 0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, cen, crst, erst, qactive, irq;
  logic [31:0] q[$];
  logic [31:0] flags = '0;
  logic [31:0] m;
  int          fails = 0;
  int          n_checks = 0;
  always #12.5 hclk = ~hclk;
  pmu_overflow_status_regs uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hnonsec(hnonsec), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .secure_access_permission(perm), .cyc_ovf_pulse(cyc_p), .evt_ovf_pulse(evt_p),
    .event_present(ev_pr), .counters_enable(cen), .cyc_cnt_reset(crst),
    .evt_cnt_reset(erst), .qactive(qactive), .irq(irq));
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One single transfer with IDLE after it
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic ns);
    @(posedge hclk);
    hsel    <= 1'b1;
    htrans  <= 2'h2;
    hwrite  <= w;
    haddr   <= {24'h0, a};
    hnonsec <= ns;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel    <= 1'b0;
    htrans  <= 2'h0;
    hwdata  <= d;
    rd_dp   <= ~w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_dp   <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ns = 0);
    bus(1'b1, a, d, ns);
  endtask
  // Note the expected word, then read
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ns = 0);
    q.push_back(e);
    bus(1'b0, a, '0, ns);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Take the oldest note at each read data phase
  always @(posedge hclk)
    if (rd_dp && hreadyout === 1'b1)
      chk(hrdata, q.pop_front());
  // Cut a hang short
  initial
  begin
    repeat (20000) @(posedge hclk);
    fails++;
    report_and_stop();
  end
  // Main sequence
  initial
  begin
    void'($urandom(32'h7147090b));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rd(OFF_CAPS, 32'h0041_7f08);
    wr(OFF_CAPS, '1);
    rd(OFF_CAPS, 32'h0041_7f08);
    rd(OFF_OVF_CLEAR, '0);
    rd(8'h40, '0);
    $display("test reset done");
    // Hardware set, W1C and W1S on the shared flags
    repeat (4)
    begin
      m = $urandom;
      @(posedge hclk);
      cyc_p <= 1'b1;
      evt_p <= m[7:0] | 8'h01;
      flags = flags | 32'h8000_0001 | {24'h0, m[7:0]};
      @(posedge hclk);
      cyc_p <= 1'b0;
      evt_p <= '0;
      rd(OFF_OVF_CLEAR, flags);
      m = $urandom & 32'h8000_00ff;
      wr(OFF_OVF_CLEAR, m);
      flags = flags & ~m;
      rd(OFF_OVF_SET, flags);
      m = $urandom & 32'h8000_00ff;
      wr(OFF_OVF_SET, m);
      flags = flags | m;
      rd(OFF_OVF_CLEAR, flags);
    end
    $display("test flags done");
    // Drive or gate the activity output
    wr(OFF_CLK_GATE, 32'h1);
    rd(OFF_CLK_GATE, 32'h1);
    idle(3);
    chk(qactive, 1'b1);
    wr(OFF_CLK_GATE, 32'h0);
    idle(3);
    chk(qactive, 1'b0);
    ev_pr <= 1'b1;
    idle(2);
    chk(qactive, 1'b1);
    ev_pr <= 1'b0;
    $display("test activity done");
    // Counter resets and master enable
    wr(OFF_GLOBAL_CTL, 32'h7);
    #1;
    chk(crst, 1'b1);
    chk(erst, 1'b1);
    chk(cen, 1'b1);
    rd(OFF_GLOBAL_CTL, 32'h1);
    rd(OFF_OVF_SET, flags);
    $display("test control done");
    // Refused access, interrupt raise, mask and clear
    wr(OFF_GLOBAL_CTL, 32'h0, 1'b1);
    rd(OFF_GLOBAL_CTL, 32'h0, 1'b1);
    rd(OFF_GLOBAL_CTL, 32'h1);
    rd(OFF_IRQ_STATUS, 32'h7);
    wr(OFF_IRQ_ENABLE, 32'h4);
    idle(2);
    chk(irq, 1'b1);
    wr(OFF_IRQ_ENABLE, 32'h0);
    idle(2);
    chk(irq, 1'b0);
    wr(OFF_IRQ_CLEAR, 32'h7);
    rd(OFF_IRQ_STATUS, 32'h0);
    for (int i = 1; i < 4; i++)
    begin
      perm <= i[1:0];
      wr(OFF_GLOBAL_CTL, {31'h0, i[0]}, 1'b1);
      rd(OFF_GLOBAL_CTL, {31'h0, i[0]}, 1'b1);
    end
    $display("test security done");
    report_and_stop();
  end
endmodule // pmu_overflow_status_regs_bench
